// ---- hdl/lfoce_ctrl.sv ----
// low-frequency oscillator and external oscillator control logic
`timescale 1ns/10ps
`default_nettype none
module lfoce_ctrl #(
  parameter logic [3:0] TRIM_CAL = lfoce_pkg::LF_TRIM_RST // calibration
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire lfoce_pkg::lfoce_sfr_req_type  sfr_req_i,
  output logic [7:0]                         sfr_rdata_o,
  input  wire logic                          lf_osc_edge_i,
  input  wire logic                          ext_osc_edge_i,
  output logic                               lowfreq_enable_o,
  output logic [3:0]                         lowfreq_trim_o,
  output logic                               lowfreq_tick_o,
  output logic                               ext_osc_enable_o,
  output logic [2:0]                         external_freq_control_o,
  output logic                               ext_clk_o,
  output logic                               crystal_terminal_in_o,
  output logic                               crystal_terminal_out_o
);
  // whole block state lives in one struct, registered once
  lfoce_pkg::lfoce_state_type st_r;   // registered state
  lfoce_pkg::lfoce_state_type st_nxt; // next state
  // decode helpers, all combinational from state, bus and lf oscillator edge
  logic wr_lf;       // write to low-frequency control
  logic wr_ext;      // write to external control
  logic div_change;  // divider select altered by write
  logic lf_settled;  // settle count reached this cycle
  logic [2:0] div_top;  // terminal count of divider
  logic x_on;        // external circuit running
  logic x_xtal;      // crystal modes
  logic x_cmos;      // cmos clock modes
  logic x_half;      // divide-by-2 modes

  // address decode and mode decode
  always_comb
  begin
    wr_lf  = sfr_req_i.wr && (sfr_req_i.addr == lfoce_pkg::LF_CTRL_ADDR);
    wr_ext = sfr_req_i.wr && (sfr_req_i.addr == lfoce_pkg::EXT_CTRL_ADDR);
    // only a real change of the divider bits drops ready
    div_change = wr_lf && (sfr_req_i.wdata[lfoce_pkg::LF_DIV_MSB:
                 lfoce_pkg::LF_DIV_LSB] != st_r.lf_div);
    // modes 00x leave both oscillator pins to the port
    x_on   = st_r.x_mode[2] | st_r.x_mode[1]; // 00x is off
    x_xtal = (st_r.x_mode == lfoce_pkg::XMODE_XTAL) ||
             (st_r.x_mode == lfoce_pkg::XMODE_XTAL_D2);
    x_cmos = (st_r.x_mode == lfoce_pkg::XMODE_CMOS) ||
             (st_r.x_mode == lfoce_pkg::XMODE_CMOS_D2);
    x_half = (st_r.x_mode == lfoce_pkg::XMODE_XTAL_D2) ||
             (st_r.x_mode == lfoce_pkg::XMODE_CMOS_D2);
    // final settle edge, counted only while enabled
    lf_settled = st_r.lf_en && lf_osc_edge_i &&
                 (st_r.lf_settle == lfoce_pkg::LF_SETTLE_EDGES - 8'h01);
  end

  // divider terminal count per select code
  always_comb
  begin
    // tick fires when the counter has reached this value
    unique case (st_r.lf_div)
      lfoce_pkg::DIV_BY8: div_top = 3'h7;
      lfoce_pkg::DIV_BY4: div_top = 3'h3;
      lfoce_pkg::DIV_BY2: div_top = 3'h1;
      lfoce_pkg::DIV_BY1: div_top = 3'h0;
    endcase
  end

  // next-state logic
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.lf_tick = 1'b0;
    // software writes to low-frequency control
    if (wr_lf)
    begin
      st_nxt.lf_en   = sfr_req_i.wdata[lfoce_pkg::LF_EN_BIT];
      st_nxt.lf_trim = sfr_req_i.wdata[lfoce_pkg::LF_TRIM_MSB:
                       lfoce_pkg::LF_TRIM_LSB];
      st_nxt.lf_div  = sfr_req_i.wdata[lfoce_pkg::LF_DIV_MSB:
                       lfoce_pkg::LF_DIV_LSB];
    end

    // a stopped oscillator clears its settle count; ready, once set, is kept
    // settle counting on oscillator edges while enabled
    if (div_change)
      st_nxt.lf_settle = 8'h00; // restart settle after divider change
    else if (!st_r.lf_en)
      st_nxt.lf_settle = 8'h00;
    else if (lf_osc_edge_i && !st_r.lf_rdy)
      st_nxt.lf_settle = st_r.lf_settle + 8'h01;

    // clearing enable alone keeps ready set; only reset or a
    // different divider select returns it to zero
    // ready: sticky, set wins over divider-change clear
    if (lf_settled)
      st_nxt.lf_rdy = 1'b1;
    else if (div_change)
      st_nxt.lf_rdy = 1'b0;

    // the tick is an enable pulse, never a derived clock
    // output divider on oscillator edges
    if (div_change || !st_r.lf_en)
      st_nxt.lf_div_cnt = 3'h0;
    else if (lf_osc_edge_i)
    begin
      if (st_r.lf_div_cnt >= div_top)
      begin
        st_nxt.lf_div_cnt = 3'h0;
        st_nxt.lf_tick    = 1'b1;
      end
      else
        st_nxt.lf_div_cnt = st_r.lf_div_cnt + 3'h1;
    end

    // software writes to external control
    if (wr_ext)
    begin
      st_nxt.x_mode = sfr_req_i.wdata[lfoce_pkg::EXT_MODE_MSB:
                      lfoce_pkg::EXT_MODE_LSB];
      st_nxt.x_freq = sfr_req_i.wdata[lfoce_pkg::EXT_FREQ_MSB:
                      lfoce_pkg::EXT_FREQ_LSB];
    end

    // a stalled crystal must drop valid, so a gap longer than
    // the limit restarts the edge count
    // valid detector: enough edges with no long gap
    if (!x_on || x_cmos || wr_ext)
    begin
      st_nxt.x_edges = 8'h00; // off, cmos or reconfigured
      st_nxt.x_gap   = 8'h00;
      st_nxt.x_vld   = 1'b0;
    end
    else if (ext_osc_edge_i)
    begin
      st_nxt.x_gap = 8'h00;
      if (st_r.x_edges == lfoce_pkg::EXT_VALID_EDGES - 8'h01)
        st_nxt.x_vld = 1'b1;
      else
        st_nxt.x_edges = st_r.x_edges + 8'h01;
    end
    else if (st_r.x_gap == lfoce_pkg::EXT_GAP_CYCLES)
    begin
      st_nxt.x_edges = 8'h00; // oscillation stalled
      st_nxt.x_vld   = 1'b0;
    end
    else
      st_nxt.x_gap = st_r.x_gap + 8'h01;

    // plain modes pass each edge pulse straight through
    // external clock out: toggle per edge when halved
    if (!x_on)
      st_nxt.x_clk = 1'b0;
    else if (x_half)
    begin
      if (ext_osc_edge_i)
        st_nxt.x_clk = ~st_r.x_clk;
    end
    else
      st_nxt.x_clk = ext_osc_edge_i;

    // read-only bits come from state, never from write data
    // read data captured on read strobe
    if (sfr_req_i.rd)
    begin
      unique case (sfr_req_i.addr)
        lfoce_pkg::LF_CTRL_ADDR:
          st_nxt.rdata = {st_r.lf_en, st_r.lf_rdy, st_r.lf_trim,
                          st_r.lf_div};
        lfoce_pkg::EXT_CTRL_ADDR:
          st_nxt.rdata = {st_r.x_vld, st_r.x_mode, 1'b0, st_r.x_freq};
        default:
          st_nxt.rdata = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // trim loads its calibrated value so the oscillator starts
  // near nominal; everything else powers up cleared
  // state register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r         <= '0;
      st_r.lf_div  <= lfoce_pkg::LF_DIV_RST;
      st_r.lf_trim <= TRIM_CAL;
      st_r.x_mode  <= lfoce_pkg::EXT_MODE_RST;
      st_r.x_freq  <= lfoce_pkg::EXT_FREQ_RST;
    end
    else
      st_r <= st_nxt;
  end

  // pin ownership decodes straight from the mode field
  // outputs
  assign sfr_rdata_o             = st_r.rdata;
  assign lowfreq_enable_o        = st_r.lf_en;
  assign lowfreq_trim_o          = st_r.lf_trim;
  assign lowfreq_tick_o          = st_r.lf_tick;
  assign ext_osc_enable_o        = x_on;
  assign external_freq_control_o = st_r.x_freq;
  assign ext_clk_o               = st_r.x_clk;
  assign crystal_terminal_in_o   = x_xtal;
  assign crystal_terminal_out_o  = x_on;
endmodule
`default_nettype wire

// ---- hdl/lfoce_pkg.sv ----
// package: register map, field layout, reset values and counts
package lfoce_pkg;
  // register addresses in the special-function-register space
  localparam logic [7:0] LF_CTRL_ADDR  = 8'h86;
  localparam logic [7:0] EXT_CTRL_ADDR = 8'hB1;
  // low-frequency control register field positions
  localparam int LF_EN_BIT   = 7;
  localparam int LF_RDY_BIT  = 6;
  localparam int LF_TRIM_MSB = 5;
  localparam int LF_TRIM_LSB = 2;
  localparam int LF_DIV_MSB  = 1;
  localparam int LF_DIV_LSB  = 0;
  // external control register field positions
  localparam int EXT_VLD_BIT   = 7;
  localparam int EXT_MODE_MSB  = 6;
  localparam int EXT_MODE_LSB  = 4;
  localparam int EXT_FREQ_MSB  = 2;
  localparam int EXT_FREQ_LSB  = 0;
  // reset values
  localparam logic [1:0] LF_DIV_RST   = 2'h0;
  localparam logic [3:0] LF_TRIM_RST  = 4'h0;
  localparam logic [2:0] EXT_MODE_RST = 3'h0;
  localparam logic [2:0] EXT_FREQ_RST = 3'h0;
  // divider select codes
  localparam logic [1:0] DIV_BY8 = 2'h0;
  localparam logic [1:0] DIV_BY4 = 2'h1;
  localparam logic [1:0] DIV_BY2 = 2'h2;
  localparam logic [1:0] DIV_BY1 = 2'h3;
  // external mode codes (00x is off)
  localparam logic [2:0] XMODE_CMOS    = 3'h2;
  localparam logic [2:0] XMODE_CMOS_D2 = 3'h3;
  localparam logic [2:0] XMODE_RC      = 3'h4;
  localparam logic [2:0] XMODE_CAP     = 3'h5;
  localparam logic [2:0] XMODE_XTAL    = 3'h6;
  localparam logic [2:0] XMODE_XTAL_D2 = 3'h7;
  // settle counts in oscillator edges, and watchdog in clock cycles
  localparam logic [7:0] LF_SETTLE_EDGES = 8'h10;
  localparam logic [7:0] EXT_VALID_EDGES = 8'h40;
  localparam int         CLK_MHZ         = 200;
  localparam int         EXT_GAP_US      = 1;
  localparam logic [7:0] EXT_GAP_CYCLES  = 8'(CLK_MHZ * EXT_GAP_US);

  // sfr bus request
  typedef struct packed {
    logic [7:0] addr; // register address
    logic       wr;   // write strobe
    logic       rd;   // read strobe
    logic [7:0] wdata;// write data
  } lfoce_sfr_req_type;

  // whole state of the block
  typedef struct packed {
    logic       lf_en;      // low-frequency enable
    logic       lf_rdy;     // low-frequency ready flag
    logic [3:0] lf_trim;    // trim field
    logic [1:0] lf_div;     // divider select
    logic [7:0] lf_settle;  // settle edge counter
    logic [2:0] lf_div_cnt; // divider counter
    logic       lf_tick;    // divided clock enable
    logic [2:0] x_mode;     // external mode select
    logic [2:0] x_freq;     // external frequency control
    logic       x_vld;      // external valid flag
    logic [7:0] x_edges;    // stable edge counter
    logic [7:0] x_gap;      // cycles since last edge
    logic       x_clk;      // external clock out level
    logic [7:0] rdata;      // read data
  } lfoce_state_type;
endpackage

// ---- bench/lfoce_ctrl_checker.sv ----
// assertions on the oscillator control ports
`timescale 1ns/10ps
`default_nettype none
module lfoce_ctrl_checker (
  input wire logic                         clk_i,
  input wire logic                         rst_n_i,
  input wire lfoce_pkg::lfoce_sfr_req_type sfr_req_i,
  input wire logic [7:0]                   sfr_rdata_o,
  input wire logic                         lf_osc_edge_i,
  input wire logic                         lowfreq_enable_o,
  input wire logic [3:0]                   lowfreq_trim_o,
  input wire logic                         lowfreq_tick_o,
  input wire logic                         ext_osc_enable_o,
  input wire logic [2:0]                   external_freq_control_o,
  input wire logic                         ext_clk_o,
  input wire logic                         crystal_terminal_in_o,
  input wire logic                         crystal_terminal_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // write and read strobes per register
  wire lf_wr = sfr_req_i.wr && sfr_req_i.addr == 8'h86;
  wire x_wr  = sfr_req_i.wr && sfr_req_i.addr == 8'hB1;
  wire bad_rd = sfr_req_i.rd && sfr_req_i.addr != 8'h86
                && sfr_req_i.addr != 8'hB1;
  wire x_rd   = sfr_req_i.rd && sfr_req_i.addr == 8'hB1;
  logic [2:0] mode_r; // mode field as last written
  // shadow of the mode field, rebuilt from the bus alone
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode_r <= 3'h0;
    else if (x_wr)
      mode_r <= sfr_req_i.wdata[6:4];
  end
  en_write_a: assert property (lf_wr |=>
    lowfreq_enable_o == $past(sfr_req_i.wdata[7])) else $error("enable");
  trim_write_a: assert property (lf_wr |=>
    lowfreq_trim_o == $past(sfr_req_i.wdata[5:2])) else $error("trim");
  freq_write_a: assert property (x_wr |=>
    external_freq_control_o == $past(sfr_req_i.wdata[2:0]))
    else $error("freq");
  xtal_pair_a: assert property (crystal_terminal_in_o |->
    crystal_terminal_out_o && ext_osc_enable_o) else $error("xtal pins");
  xout_mode_a: assert property (crystal_terminal_out_o ==
    (mode_r[2:1] != 2'b00)) else $error("out pin");
  xin_mode_a: assert property (crystal_terminal_in_o ==
    (mode_r[2:1] == 2'b11)) else $error("in pin");
  bad_read_a: assert property (bad_rd |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read");
  tick_edge_a: assert property (lowfreq_tick_o |->
    $past(lf_osc_edge_i)) else $error("tick");
  off_clk_a: assert property (!ext_osc_enable_o [*2] |->
    !ext_clk_o) else $error("clock while off");
  tick_off_a: assert property (!lowfreq_enable_o [*2] |->
    !lowfreq_tick_o) else $error("tick while off");
  cmos_vld_a: assert property (x_rd && mode_r[2:1] == 2'b01 |=>
    !sfr_rdata_o[7]) else $error("valid in cmos mode");
endmodule
bind lfoce_ctrl lfoce_ctrl_checker u_lfoce_ctrl_checker (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
  .lf_osc_edge_i(lf_osc_edge_i), .lowfreq_enable_o(lowfreq_enable_o),
  .lowfreq_trim_o(lowfreq_trim_o), .lowfreq_tick_o(lowfreq_tick_o),
  .ext_osc_enable_o(ext_osc_enable_o), .ext_clk_o(ext_clk_o),
  .external_freq_control_o(external_freq_control_o),
  .crystal_terminal_in_o(crystal_terminal_in_o),
  .crystal_terminal_out_o(crystal_terminal_out_o));
`default_nettype wire

// ---- bench/lfoce_osc_model.sv ----
// oscillator edge source outside the control block
`timescale 1ns/10ps
`default_nettype none
module lfoce_osc_model (
  input  wire logic clk_i,
  input  wire logic lf_run_i,
  input  wire logic ext_run_i,
  output logic      lf_edge_o = 1'b0,
  output logic      ext_edge_o = 1'b0
);
  logic [1:0] cnt_r = 2'h0; // phase counter
  // lf edge every fourth cycle, ext every second, only while powered
  always_ff @(posedge clk_i)
  begin
    cnt_r      <= cnt_r + 2'h1;
    lf_edge_o  <= lf_run_i && cnt_r == 2'h3;
    ext_edge_o <= ext_run_i && cnt_r[0];
  end
endmodule
`default_nettype wire

// ---- bench/tb_lfoce_ctrl.sv ----
// self-checking bench for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
module tb_lfoce_ctrl;
  logic                         clk_i = 1'b0;
  logic                         rst_n_i = 1'b0;
  lfoce_pkg::lfoce_sfr_req_type req = '0;
  logic [7:0]                   rdata;
  logic                         lf_edge, ext_edge, lf_en, tick;
  logic                         x_en, xclk, xin, xout;
  logic [3:0]                   trim, t;
  logic [2:0]                   xfreq, f;
  logic [7:0]                   q[$]; // expected read data
  logic                         rd_d = 1'b0;
  int                           miscompares = 0;
  int                           n_tests = 0;
  int                           seed = 65049;
  int                           hi = 0;
  int                           ticks = 0;
  lfoce_ctrl u_lfoce_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sfr_req_i(req), .sfr_rdata_o(rdata), .lf_osc_edge_i(lf_edge),
    .ext_osc_edge_i(ext_edge), .lowfreq_enable_o(lf_en),
    .lowfreq_trim_o(trim), .lowfreq_tick_o(tick), .ext_osc_enable_o(x_en),
    .external_freq_control_o(xfreq), .ext_clk_o(xclk),
    .crystal_terminal_in_o(xin), .crystal_terminal_out_o(xout));
  lfoce_osc_model u_lfoce_osc_model (.clk_i(clk_i), .lf_run_i(lf_en),
    .ext_run_i(x_en), .lf_edge_o(lf_edge), .ext_edge_o(ext_edge));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // one bus cycle; a read notes its expected data
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(negedge clk_i);
    req.addr = a;
    req.wr = w;
    req.rd = !w;
    req.wdata = d;
    if (!w) q.push_back(d);
    @(negedge clk_i);
    req.wr = 1'b0;
    req.rd = 1'b0;
  endtask
  task automatic end_sim;
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // read watcher: oldest note against the data one cycle after rd
  always @(posedge clk_i) rd_d <= req.rd;
  always @(negedge clk_i) if (rd_d) chk(rdata, q.pop_front());
  initial forever #2.5 clk_i = ~clk_i;
  initial
  begin
    #50000; // about five times the length of all scenarios
    miscompares++;
    end_sim;
  end
  initial
  begin
    t = 4'($random(seed));
    f = 3'($random(seed));
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    acc(8'h86, 1'b0, 8'h00);
    acc(8'hB1, 1'b0, 8'h00);
    acc(8'h86, 1'b1, {2'b10, t, 2'b11});
    chk({lf_en, 3'h0, trim}, {4'h8, t});
    acc(8'h86, 1'b0, {2'b10, t, 2'b11});
    repeat (80) @(negedge clk_i);
    acc(8'h86, 1'b0, {2'b11, t, 2'b11});
    acc(8'h86, 1'b1, {2'b00, t, 2'b11});
    acc(8'h86, 1'b0, {2'b01, t, 2'b11});
    acc(8'h86, 1'b1, {2'b00, t, 2'b00});
    acc(8'h87, 1'b1, 8'hFF);
    acc(8'h87, 1'b0, 8'h00);
    acc(8'h86, 1'b0, {2'b00, t, 2'b00});
    // tick count per divider select over 80 oscillator edges
    for (int d = 0; d < 4; d++)
    begin
      acc(8'h86, 1'b1, {2'b10, t, 2'(d)});
      repeat (8) @(negedge clk_i);
      ticks = 0;
      repeat (320) @(negedge clk_i) ticks += tick;
      chk(8'(ticks), 8'(80 >> (3 - d)));
    end
    for (int m = 0; m < 8; m++)
    begin
      acc(8'hB1, 1'b1, {1'b0, 3'(m), 1'b0, f});
      chk({xin, xout, x_en, xfreq}, {m >= 6, m >= 2, m >= 2, f});
    end
    repeat (200) @(negedge clk_i);
    acc(8'hB1, 1'b0, {4'hF, 1'b0, f});
    repeat (40) @(negedge clk_i) hi += xclk;
    chk(8'(hi), 8'h14);
    acc(8'hB1, 1'b1, {4'h2, 1'b0, f});
    repeat (200) @(negedge clk_i);
    acc(8'hB1, 1'b0, {4'h2, 1'b0, f});
    // ready still set, then a reset in mid-run must clear it
    acc(8'h86, 1'b0, {2'b11, t, 2'b11});
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    acc(8'h86, 1'b0, {2'b00, lfoce_pkg::LF_TRIM_RST, 2'b00});
    acc(8'hB1, 1'b0, 8'h00);
    end_sim;
  end
endmodule
`default_nettype wire
